// file: core/pmurmc_core.sv
// Rail mode controller: sequencing, rail enables, discharge and Avalon-MM registers.
//
// The Avalon-MM interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Button or hold input turns on rails one, five, six and seven.
// - Hold and core enable with no disables keep all seven rails on.
// - Normal mode: rails six and seven disabled, rails one to five stay on.
// - Sleep mode: hold only, six and seven disabled, only rails one and five on.
// - No hold, no core enable, no button: all rails off.
// - A disabled linear rail with its discharge bit set gets its discharge path.
// - Button starts rail one, then five to seven, reset held until timer expires.
// - Button released before hold or core enable: start-up ends, all rails off.
// - Button status output pulled low while the button is asserted.
module pmurmc_core
    import pmurmc_pkg::*;
#(
    parameter int RESET_TIMEOUT_CYCLES = RESET_TIMEOUT_CYC
) (
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        push_button_in_n,
    input  wire logic        hold_rail_enable_in,
    input  wire logic        core_rail_enable_in,
    input  wire logic        rail_one_good_in,
    output logic      [6:0]  rail_enable,
    output logic      [6:0]  discharge_enable,
    output logic             cpu_reset_out_n,
    output logic             cpu_reset_oe,
    output logic             button_status_out_n,
    output logic             button_status_oe
);

    localparam int TW = $clog2(RESET_TIMEOUT_CYCLES + 1);
    localparam logic [TW-1:0] TIMER_LAST = TW'(RESET_TIMEOUT_CYCLES - 1);

    function automatic logic [6:0] railRequest(input logic button, input logic hold, input logic core,
                                               input logic [6:0] railDisable);
        logic [6:0] want;
        want = ((button | hold) ? ALWAYS_ON_MASK : 7'h00) | (core ? CORE_RAIL_MASK : 7'h00);
        return want & ~railDisable;
    endfunction : railRequest

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers.

    logic [1:0] buttonSync_reg;
    logic [1:0] holdSync_reg;
    logic [1:0] coreSync_reg;
    logic [1:0] goodSync_reg;
    logic       buttonPrev_reg;

    // Every pin has its own two-stage synchroniser, and only the second stage feeds any logic.
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            buttonSync_reg <= SYNC_HIGH_RST;
        end else begin
            buttonSync_reg <= {buttonSync_reg[0], push_button_in_n};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            holdSync_reg <= SYNC_LOW_RST;
        end else begin
            holdSync_reg <= {holdSync_reg[0], hold_rail_enable_in};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            coreSync_reg <= SYNC_LOW_RST;
        end else begin
            coreSync_reg <= {coreSync_reg[0], core_rail_enable_in};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            goodSync_reg <= SYNC_LOW_RST;
        end else begin
            goodSync_reg <= {goodSync_reg[0], rail_one_good_in};
        end
    end

    // The edge detector starts at the released level, so leaving reset never looks like a press.
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            buttonPrev_reg <= 1'b0;
        end else begin
            buttonPrev_reg <= ~buttonSync_reg[1];
        end
    end

    wire logic buttonOn   = ~buttonSync_reg[1];
    wire logic holdOn     = holdSync_reg[1];
    wire logic coreOn     = coreSync_reg[1];
    wire logic railGood   = goodSync_reg[1];
    wire logic buttonRise = buttonOn & ~buttonPrev_reg;
    // Nobody in control: no button, no hold, no core enable.
    wire logic released   = ~buttonOn & ~holdOn & ~coreOn;

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Register slave: one wait cycle, then the access completes.

    pmurmc_ctrl_type  ctrl_reg;
    pmurmc_ctrl_type  ctrl_next;
    pmurmc_state_type state_reg;
    pmurmc_state_type state_next;
    logic             ack_reg;
    logic [31:0]      readData_reg;
    logic [6:0]       rail_reg;
    logic [6:0]       rail_next;
    logic [6:0]       disch_reg;
    logic             cpuReset_reg;
    logic [TW-1:0]    timer_reg;
    logic [TW-1:0]    timer_next;

    wire logic        access     = avs_read | avs_write;
    wire logic        hitControl = (avs_address == ADDR_CONTROL);
    wire logic        hitStatus  = (avs_address == ADDR_STATUS);
    wire logic        writeCtrl  = avs_write & ack_reg & hitControl;
    wire logic        resetLow   = ~cpuReset_reg;

    // Each field is widened on its own, so no inversion or shift is done at the wrong width.
    wire logic [31:0] statRail   = 32'(rail_reg) << STAT_RAIL_LSB;
    wire logic [31:0] statDisch  = 32'(disch_reg) << STAT_DISCH_LSB;
    wire logic [31:0] statState  = 32'(state_reg) << STAT_STATE_LSB;
    wire logic [31:0] statReset  = 32'(resetLow) << STAT_RESET_BIT;
    wire logic [31:0] statButton = 32'(buttonOn) << STAT_BUTTON_BIT;
    wire logic [31:0] statGood   = 32'(railGood) << STAT_GOOD_BIT;
    wire logic [31:0] statusWord = statRail | statDisch | statState | statReset | statButton | statGood;
    wire logic [31:0] ctrlDis    = 32'(ctrl_reg.railDisable) << CTRL_DISABLE_LSB;
    wire logic [31:0] ctrlDisch  = 32'(ctrl_reg.discharge) << CTRL_DISCH_LSB;
    wire logic [31:0] ctrlWord   = ctrlDis | ctrlDisch;

    wire logic [31:0] readMux    = hitControl ? ctrlWord : (hitStatus ? statusWord : 32'h0000_0000);
    wire logic [6:0]  wrDisable  = avs_byteenable[0] ? avs_writedata[CTRL_DISABLE_LSB +: 7] : ctrl_reg.railDisable;
    wire logic [6:0]  wrDisch    = avs_byteenable[1] ? avs_writedata[CTRL_DISCH_LSB +: 7] : ctrl_reg.discharge;
    wire logic        ack_next   = access & ~ack_reg;
    // Read data are captured in the wait cycle and then stand until the next read is taken.
    wire logic        readTake   = avs_read & ~ack_reg;
    wire logic [31:0] readData_next = readTake ? readMux : readData_reg;

    assign avs_waitrequest = access & ~ack_reg;
    assign avs_readdata    = readData_reg;

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= ack_next;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            readData_reg <= 32'h0000_0000;
        end else begin
            readData_reg <= readData_next;
        end
    end

    wire logic wakeOtg  = (state_reg == ST_RUN) & buttonRise;
    wire logic goingOff = (state_next == ST_OFF);

    // Power-down clears the disables so no rail stays disabled at the next start-up. A button press
    // while running wakes rails six and seven; the hardware action outranks a write in that cycle.
    always_comb begin
        ctrl_next = ctrl_reg;
        if (writeCtrl) begin
            ctrl_next.railDisable = wrDisable;
            ctrl_next.discharge   = wrDisch;
        end
        if (wakeOtg) begin
            ctrl_next.railDisable = ctrl_next.railDisable & ~OTG_RAIL_MASK;
        end
        if (goingOff) begin
            ctrl_next.railDisable = CTRL_DISABLE_RST;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Sequencer.

    // The timer stops at its last count, so a late power-good leaves it parked there.
    wire logic timerDone = (timer_reg == TIMER_LAST);

    always_comb begin
        state_next = state_reg;
        rail_next  = 7'h00;
        timer_next = '0;
        case (state_reg)
            ST_OFF: begin
                if (buttonOn) begin
                    state_next = ST_RAMP;
                end
            end
            ST_RAMP: begin
                rail_next = RAIL_ONE_MASK;
                if (!buttonOn) begin
                    state_next = ST_OFF;
                end else if (railGood) begin
                    state_next = ST_RESET;
                end
            end
            ST_RESET: begin
                rail_next  = railRequest(buttonOn, holdOn, coreOn, ctrl_reg.railDisable);
                timer_next = timerDone ? timer_reg : timer_reg + 1'b1;
                if (released) begin
                    state_next = ST_OFF;
                    rail_next  = 7'h00;
                end else if (timerDone && railGood) begin
                    state_next = ST_RUN;
                end
            end
            ST_RUN: begin
                // The core enable input is a level from the processor.
                rail_next = railRequest(buttonOn, holdOn, coreOn, ctrl_reg.railDisable);
                if (released) begin
                    state_next = ST_OFF;
                    rail_next  = 7'h00;
                end
            end
            default: begin
                state_next = ST_OFF;
            end
        endcase
    end

    // Discharge follows the next rail value, so a path never opens while its rail is still lit.
    wire logic [6:0] disch_next    = ~rail_next & ctrl_next.discharge & LDO_RAIL_MASK;
    wire logic       cpuReset_next = (state_next == ST_RUN);

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            state_reg <= ST_OFF;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            ctrl_reg <= '{discharge: CTRL_DISCH_RST, railDisable: CTRL_DISABLE_RST};
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            timer_reg <= '0;
        end else begin
            timer_reg <= timer_next;
        end
    end

    // Rails change only at a clock edge, so a mode change never shows a passing enable pulse.
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            rail_reg <= 7'h00;
        end else begin
            rail_reg <= rail_next;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            disch_reg <= 7'h00;
        end else begin
            disch_reg <= disch_next;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            cpuReset_reg <= 1'b0;
        end else begin
            cpuReset_reg <= cpuReset_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Outputs. Open-drain pins drive low only while enabled.

    assign rail_enable         = rail_reg;
    assign discharge_enable    = disch_reg;
    assign cpu_reset_out_n     = 1'b0;
    assign cpu_reset_oe        = ~cpuReset_reg;
    assign button_status_out_n = 1'b0;
    assign button_status_oe    = buttonOn;

endmodule : pmurmc_core

`default_nettype wire

// file: core/pmurmc_pkg.sv
// Package with constants, types and register layout of the rail mode controller.
package pmurmc_pkg;

    localparam int          RAIL_COUNT        = 7;
    // Rail bit positions: bit 0 is rail one, bit 6 is rail seven.
    localparam logic [6:0]  ALWAYS_ON_MASK    = 7'h71;
    localparam logic [6:0]  CORE_RAIL_MASK    = 7'h0e;
    localparam logic [6:0]  LDO_RAIL_MASK     = 7'h78;
    localparam logic [6:0]  RAIL_ONE_MASK     = 7'h01;
    localparam logic [6:0]  OTG_RAIL_MASK     = 7'h60;

    // Register map, byte addresses on the word-aligned slave.
    localparam logic [3:0]  ADDR_CONTROL      = 4'h0;
    localparam logic [3:0]  ADDR_STATUS       = 4'h4;

    // Control register field positions.
    localparam int          CTRL_DISABLE_LSB  = 0;
    localparam int          CTRL_DISCH_LSB    = 8;
    // Status register field positions.
    localparam int          STAT_RAIL_LSB     = 0;
    localparam int          STAT_DISCH_LSB    = 8;
    localparam int          STAT_STATE_LSB    = 16;
    localparam int          STAT_RESET_BIT    = 20;
    localparam int          STAT_BUTTON_BIT   = 21;
    localparam int          STAT_GOOD_BIT     = 22;

    localparam logic [6:0]  CTRL_DISABLE_RST  = 7'h00;
    localparam logic [6:0]  CTRL_DISCH_RST    = 7'h00;
    localparam logic [1:0]  SYNC_HIGH_RST     = 2'h3;
    localparam logic [1:0]  SYNC_LOW_RST      = 2'h0;

    // Clock and reset timeout.
    localparam int          CLK_PERIOD_NS     = 50;
    localparam int          RESET_TIMEOUT_NS  = 1000000;
    localparam int          RESET_TIMEOUT_CYC = (RESET_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef struct packed {
        logic [6:0] discharge;
        logic [6:0] railDisable;
    } pmurmc_ctrl_type;

    typedef enum logic [2:0] {
        ST_OFF,
        ST_RAMP,
        ST_RESET,
        ST_RUN
    } pmurmc_state_type;

endpackage : pmurmc_pkg

// file: testbench/pmurmc_core_asserts.sv
// Concurrent checks on the ports of the rail mode controller.
`timescale 1ns/1ps
`default_nettype none
module pmurmc_core_asserts
    import pmurmc_pkg::*;
#(
    parameter int RESET_TIMEOUT_CYCLES = 8
) (
    input wire logic        clk_sys,
    input wire logic        reset_n,
    input wire logic [3:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        push_button_in_n,
    input wire logic        hold_rail_enable_in,
    input wire logic        core_rail_enable_in,
    input wire logic [6:0]  rail_enable,
    input wire logic [6:0]  discharge_enable,
    input wire logic        cpu_reset_out_n,
    input wire logic        cpu_reset_oe,
    input wire logic        button_status_out_n,
    input wire logic        button_status_oe
);
    int rstCnt;
    // Counts the cycles spent in reset with rail five lit.
    always_ff @(posedge clk_sys) begin
        if (!reset_n || !cpu_reset_oe) rstCnt <= 0;
        else if (rail_enable[4]) rstCnt <= rstCnt + 1;
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    a_bus_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus answer late");
    a_bus_idle: assert property (!avs_read && !avs_write |-> !avs_waitrequest) else $error("idle wait");
    a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address != 4'h0
        && avs_address != 4'h4 |-> avs_readdata == 32'h0) else $error("unmapped read");
    a_button_press: assert property (!push_button_in_n [*3] |-> button_status_oe) else $error("status off");
    a_button_free: assert property (push_button_in_n [*3] |-> !button_status_oe) else $error("status on");
    a_pin_levels: assert property (cpu_reset_out_n == 1'b0 && button_status_out_n == 1'b0)
        else $error("pin data");
    a_discharge_off: assert property ((discharge_enable & (rail_enable | 7'h07)) == 7'h00)
        else $error("discharge on live rail");
    a_all_off: assert property ((!hold_rail_enable_in && !core_rail_enable_in && push_button_in_n) [*6]
        |-> rail_enable == 7'h00) else $error("rails left on");
    a_reset_timer: assert property ($fell(cpu_reset_oe) |-> rstCnt >= RESET_TIMEOUT_CYCLES - 1)
        else $error("reset short");
    a_rail_order: assert property ($rose(rail_enable[4]) && cpu_reset_oe |-> $past(rail_enable[0]))
        else $error("rail order");
endmodule : pmurmc_core_asserts
bind pmurmc_core pmurmc_core_asserts #(.RESET_TIMEOUT_CYCLES(RESET_TIMEOUT_CYCLES)) i_pmurmc_core_asserts (
    .clk_sys, .reset_n, .avs_address, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest,
    .push_button_in_n, .hold_rail_enable_in, .core_rail_enable_in, .rail_enable, .discharge_enable,
    .cpu_reset_out_n, .cpu_reset_oe, .button_status_out_n, .button_status_oe);
`default_nettype wire

// file: testbench/pmurmc_cpu_model.sv
// Processor model: boots after reset, then drives the hold and core enable levels.
`timescale 1ns/1ps
`default_nettype none
module pmurmc_cpu_model (
    input wire logic       clk_sys,
    input wire logic [6:0] rail_enable,
    input wire logic       cpu_reset_oe,
    input wire logic       bootOk,
    input wire logic [3:0] bootDelay,
    input wire logic       holdReq,
    input wire logic       coreReq,
    output logic           hold_rail_enable_in,
    output logic           core_rail_enable_in
);
    logic [4:0] bootCnt = 5'h00;
    logic       booted  = 1'b0;
    // A failed boot never takes control, so the button release must shut down.
    always @(posedge clk_sys) begin
        if (rail_enable == 7'h00) begin
            bootCnt <= 5'h00;
            booted  <= 1'b0;
        end else if (!cpu_reset_oe && bootOk && bootCnt == {1'b0, bootDelay}) booted <= 1'b1;
        else if (!cpu_reset_oe) bootCnt <= bootCnt + 5'h01;
    end
    assign hold_rail_enable_in = booted && holdReq;
    assign core_rail_enable_in = booted && coreReq;
endmodule : pmurmc_cpu_model
`default_nettype wire

// file: testbench/tb_pmu_rail_mode_control.sv
// Self-checking bench for the rail mode controller.
`timescale 1ns/1ps
`default_nettype none
module tb_pmu_rail_mode_control
    import pmurmc_pkg::*;
;
    logic        clk_sys = 1'b0, reset_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
    logic        push_button_in_n = 1'b1, rail_one_good_in = 1'b0, bootOk = 1'b0, holdReq = 1'b1, coreReq = 1'b1;
    logic [3:0]  avs_address = 4'h0, avs_byteenable = 4'h0, bootDelay = 4'h0;
    logic [31:0] avs_writedata = 32'h0, rd, seed = 32'hbead;
    logic [6:0]  dis;
    logic        cr;
    int          error_cnt = 0, check_count = 0;
    wire logic [31:0] avs_readdata;
    wire logic [6:0]  rail_enable, discharge_enable;
    wire logic        avs_waitrequest, hold_rail_enable_in, core_rail_enable_in, cpu_reset_out_n, cpu_reset_oe;
    wire logic        button_status_out_n, button_status_oe;
    pmurmc_core #(.RESET_TIMEOUT_CYCLES(8)) i_pmurmc_core (.clk_sys, .reset_n, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .push_button_in_n,
        .hold_rail_enable_in, .core_rail_enable_in, .rail_one_good_in, .rail_enable, .discharge_enable,
        .cpu_reset_out_n, .cpu_reset_oe, .button_status_out_n, .button_status_oe);
    pmurmc_cpu_model i_pmurmc_cpu_model (.clk_sys, .rail_enable, .cpu_reset_oe, .bootOk, .bootDelay,
        .holdReq, .coreReq, .hold_rail_enable_in, .core_rail_enable_in);
    always #25 clk_sys = ~clk_sys;
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic [6:0] expRails(input logic core, input logic [6:0] d);
        return (ALWAYS_ON_MASK | (core ? CORE_RAIL_MASK : 7'h00)) & ~d;
    endfunction : expRails
    task automatic wt(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : wt
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Holds the request until waitrequest is seen low, then releases it one edge clear of the next call.
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        avs_address    <= a;
        avs_writedata  <= d;
        avs_byteenable <= 4'h3;
        avs_read       <= !wr;
        avs_write      <= wr;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk_sys);
    endtask : bus
    task automatic powerUp(input logic ok);
        bootOk           <= ok;
        push_button_in_n <= 1'b0;
        wt(6);
        chk(rail_enable, RAIL_ONE_MASK);
        chk(button_status_oe, 1'b1);
        rail_one_good_in <= 1'b1;
        wt(6);
        chk(cpu_reset_oe, 1'b1);
        wt(30);
        chk(cpu_reset_oe, 1'b0);
        chk(rail_enable, ok ? 7'h7f : ALWAYS_ON_MASK);
        push_button_in_n <= 1'b1;
        wt(6);
        chk(button_status_oe, 1'b0);
    endtask : powerUp
    task automatic test_done;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : test_done
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        wt(5);
        reset_n <= 1'b1;
        wt(2);
        chk(rail_enable, 7'h00);
        powerUp(1'b0);
        chk(rail_enable, 7'h00);
        rail_one_good_in <= 1'b0;
        wt(4);
        $display("test boot abort done");
        seed = lfsr(seed);
        bootDelay <= seed[3:0];
        powerUp(1'b1);
        chk(rail_enable, 7'h7f);
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            dis = (i < 2) ? OTG_RAIL_MASK : seed[6:0] & 7'h7e;
            cr = (i == 0) | ((i != 1) & seed[16]);
            coreReq <= cr;
            bus(1'b1, ADDR_CONTROL, {17'h0, seed[14:8], 1'b0, dis}, rd);
            wt(6);
            chk(rail_enable, expRails(cr, dis));
            chk(discharge_enable, seed[14:8] & ~expRails(cr, dis) & LDO_RAIL_MASK);
            bus(1'b0, ADDR_STATUS, 32'h0, rd);
            chk(rd[6:0], expRails(cr, dis));
            bus(1'b0, ADDR_CONTROL, 32'h0, rd);
            chk(rd, {17'h0, seed[14:8], 1'b0, dis});
        end
        bus(1'b0, 4'h8, 32'h0, rd);
        chk(rd, 32'h0);
        $display("test modes done");
        coreReq <= 1'b0;
        bus(1'b1, ADDR_CONTROL, {17'h0, OTG_RAIL_MASK, 1'b0, OTG_RAIL_MASK}, rd);
        wt(6);
        chk(rail_enable, ALWAYS_ON_MASK & ~OTG_RAIL_MASK);
        chk(discharge_enable, OTG_RAIL_MASK);
        push_button_in_n <= 1'b0;
        wt(6);
        chk(rail_enable, ALWAYS_ON_MASK);
        chk(discharge_enable, 7'h00);
        push_button_in_n <= 1'b1;
        coreReq          <= 1'b1;
        wt(6);
        chk(rail_enable, 7'h7f);
        $display("test wake done");
        holdReq <= 1'b0;
        coreReq <= 1'b0;
        wt(6);
        chk(rail_enable, 7'h00);
        $display("test shutdown done");
        test_done();
    end
    initial begin
        wt(5000);
        error_cnt++;
        test_done();
    end
endmodule : tb_pmu_rail_mode_control
`default_nettype wire
